// File: design/lsp_top.sv
// Purpose: register port and integration timing of a light-to-digital converter
// Assumes: scl, sda and strap are asynchronous pins; light level comes from
//   front-end logic on the same clock
// Notes: sda is open drain; the block only ever pulls it low
// What this block does
// - answer address 100010 plus strap level
// - compare seven bits, eighth is direction
// - master clocks; data line shared by phase
// - receiver pulls data low at acknowledge
// - setup registers hold until rewritten
// - two bytes show latest light result
// - two bytes show previous period cycle tally
// - result is sixteen-bit light count
// - internal mode: oscillator plus selectable counter
// - external mode: period between restart commands
// - four gain ranges, dim to bright
// - operation setup fields, bit four zero
// - range bits three and two only
// - pointer bit seven restarts integration
// - pointer bit six clears pending interrupt
// - width code picks 65536/4096/256/16 cycles
// - only mode code 10 converts
// - run bit and power-down gate converter
// - tally counts cycles, latched at period end
`timescale 1ns/1ps
module lsp_top #(
	parameter int CYC_SEL0 = lsp_pkg::CYC_W0,
	parameter int CYC_SEL1 = lsp_pkg::CYC_W1,
	parameter int CYC_SEL2 = lsp_pkg::CYC_W2,
	parameter int CYC_SEL3 = lsp_pkg::CYC_W3,
	parameter int DIV_SLOW = lsp_pkg::OSC_DIV_SLOW,
	parameter int DIV_FAST = lsp_pkg::OSC_DIV_FAST
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_strap_pin,
	input wire logic [15:0] light_level,
	input wire logic irq_event,
	output lsp_pkg::lsp_op_setup_t op_setup,
	output logic [1:0] range_sel,
	output logic integ_end,
	output logic irq_pending
);

	// slave sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_REG,
		ST_WDATA,
		ST_RDATA,
		ST_WAIT
	} lsp_state_t;

	lsp_pkg::lsp_pins_t pins; // synchronised pins
	lsp_pkg::lsp_pins_t pins_prev_reg; // previous synchronised levels
	lsp_state_t state_reg; // sequencer state
	logic [3:0] bit_cnt_reg; // bits seen in current byte
	logic ack_phase_reg; // inside the ninth clock
	logic [7:0] shift_reg; // received byte
	logic [7:0] tx_reg; // byte being sent
	logic [7:0] ptr_reg; // selected register
	logic [7:0] wr_data_reg; // byte to store
	logic wr_stb_reg; // one-cycle store request
	logic restart_stb_reg; // one-cycle restart request
	logic clr_stb_reg; // one-cycle interrupt clear
	logic nack_reg; // master refused further data
	logic [15:0] count_reg; // latest light result
	logic [15:0] tally_reg; // latched cycle tally
	logic [15:0] tally_cnt_reg; // running cycle tally
	logic [16:0] cyc_cnt_reg; // oscillator cycles this period
	logic [8:0] osc_div_reg; // oscillator divider

	// pins enter through two flops
	lsp_sync2 #(
		.WIDTH(3)
	) u_sync (
		.clock(clock),
		.rst(rst),
		.async_in({scl_in, sda_in, addr_strap_pin}),
		.sync_out(pins)
	);

	// edge and condition detection on synchronised levels
	wire scl_rise = pins.scl && !pins_prev_reg.scl;
	wire scl_fall = !pins.scl && pins_prev_reg.scl;
	wire start_det = pins.scl && pins_prev_reg.scl && pins_prev_reg.sda && !pins.sda;
	wire stop_det = pins.scl && pins_prev_reg.scl && !pins_prev_reg.sda && pins.sda;
	wire busy = (state_reg != ST_IDLE) && (state_reg != ST_WAIT);
	wire byte_done = !ack_phase_reg && (bit_cnt_reg == 4'h8);

	// address compare: fixed upper bits, strap as bit zero
	wire [6:0] own_addr = {lsp_pkg::ADDR_UPPER, pins.strap};
	wire addr_match = (shift_reg[7:1] == own_addr);
	wire read_dir = shift_reg[0];

	// read selection
	wire [7:0] range_byte = {4'h0, range_sel, 2'h0};
	wire [7:0] rd_byte = (ptr_reg == lsp_pkg::OFF_OP_SETUP) ? op_setup :
		(ptr_reg == lsp_pkg::OFF_RANGE_SETUP) ? range_byte :
		(ptr_reg == lsp_pkg::OFF_COUNT_LOW) ? count_reg[7:0] :
		(ptr_reg == lsp_pkg::OFF_COUNT_HIGH) ? count_reg[15:8] :
		(ptr_reg == lsp_pkg::OFF_TALLY_LOW) ? tally_reg[7:0] :
		(ptr_reg == lsp_pkg::OFF_TALLY_HIGH) ? tally_reg[15:8] : 8'h00;

	// remember last levels for edge detection
	always_ff @(posedge clock) begin
		if (rst) begin
			pins_prev_reg <= '1;
		end else begin
			pins_prev_reg <= pins;
		end
	end

	// slave sequencer: bits shift in on rising scl, sda changes on falling scl
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			ack_phase_reg <= 1'b0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
			wr_stb_reg <= 1'b0;
			restart_stb_reg <= 1'b0;
			clr_stb_reg <= 1'b0;
			nack_reg <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			wr_stb_reg <= 1'b0;
			restart_stb_reg <= 1'b0;
			clr_stb_reg <= 1'b0;
			if (start_det) begin
				// start or repeated start: fresh address byte
				state_reg <= ST_ADDR;
				bit_cnt_reg <= 4'h0;
				ack_phase_reg <= 1'b0;
				sda_oe <= 1'b0;
			end else if (stop_det) begin
				// stop: let go of the line
				state_reg <= ST_IDLE;
				ack_phase_reg <= 1'b0;
				sda_oe <= 1'b0;
			end else if (scl_rise && busy) begin
				if (!ack_phase_reg) begin
					shift_reg <= {shift_reg[6:0], pins.sda};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end else begin
					// master answer after a byte we sent
					nack_reg <= pins.sda;
				end
			end else if (scl_fall && busy) begin
				if (byte_done) begin
					ack_phase_reg <= 1'b1;
					bit_cnt_reg <= 4'h0;
					case (state_reg)
						ST_ADDR: begin
							if (addr_match) begin
								sda_oe <= 1'b1;
							end else begin
								// not ours: ignore until next start
								state_reg <= ST_WAIT;
								ack_phase_reg <= 1'b0;
							end
						end
						ST_REG: begin
							sda_oe <= 1'b1;
							ptr_reg <= shift_reg;
							restart_stb_reg <= shift_reg[lsp_pkg::PTR_RESTART_BIT];
							clr_stb_reg <= shift_reg[lsp_pkg::PTR_IRQ_CLEAR_BIT];
						end
						ST_WDATA: begin
							sda_oe <= 1'b1;
							wr_data_reg <= shift_reg;
							wr_stb_reg <= 1'b1;
						end
						ST_RDATA: begin
							// master acknowledges, release line
							sda_oe <= 1'b0;
						end
						default: begin
							sda_oe <= 1'b0;
						end
					endcase
				end else if (ack_phase_reg) begin
					// end of ninth clock: next phase
					ack_phase_reg <= 1'b0;
					case (state_reg)
						ST_ADDR: begin
							if (read_dir) begin
								state_reg <= ST_RDATA;
								tx_reg <= rd_byte;
								sda_oe <= !rd_byte[7];
							end else begin
								state_reg <= ST_REG;
								sda_oe <= 1'b0;
							end
						end
						ST_REG: begin
							state_reg <= ST_WDATA;
							sda_oe <= 1'b0;
						end
						ST_WDATA: begin
							sda_oe <= 1'b0;
						end
						ST_RDATA: begin
							if (nack_reg) begin
								state_reg <= ST_WAIT;
								sda_oe <= 1'b0;
							end else begin
								tx_reg <= rd_byte;
								sda_oe <= !rd_byte[7];
							end
						end
						default: begin
							sda_oe <= 1'b0;
						end
					endcase
				end else if (state_reg == ST_RDATA) begin
					// next data bit, pulled low only for a zero
					tx_reg <= {tx_reg[6:0], 1'b0};
					sda_oe <= !tx_reg[6];
				end
			end
		end
	end

	// line value is always low; the enable does the signalling
	always_ff @(posedge clock) begin
		if (rst) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// reset value of the range field, cut from the full register
	localparam logic [1:0] RANGE_SETUP_RESET_BITS =
		lsp_pkg::RANGE_SETUP_RESET[lsp_pkg::RANGE_MSB:lsp_pkg::RANGE_LSB];

	// setup registers change only on a store
	always_ff @(posedge clock) begin
		if (rst) begin
			op_setup <= lsp_pkg::OP_SETUP_RESET;
			range_sel <= RANGE_SETUP_RESET_BITS;
		end else if (wr_stb_reg) begin
			if (ptr_reg == lsp_pkg::OFF_OP_SETUP) begin
				op_setup <= {wr_data_reg[7:5], 1'b0, wr_data_reg[3:0]};
			end
			if (ptr_reg == lsp_pkg::OFF_RANGE_SETUP) begin
				range_sel <= wr_data_reg[lsp_pkg::RANGE_MSB:lsp_pkg::RANGE_LSB];
			end
		end
	end

	// pending interrupt: a new event wins over a clear
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_pending <= 1'b0;
		end else if (irq_event) begin
			irq_pending <= 1'b1;
		end else if (clr_stb_reg) begin
			irq_pending <= 1'b0;
		end
	end

	// converter runs only when enabled, powered and in light mode
	wire [1:0] conv_mode = {op_setup.conv_mode_hi, op_setup.conv_mode_lo};
	wire active = op_setup.converter_run_bit && !op_setup.power_down_bit &&
		(conv_mode == lsp_pkg::MODE_LIGHT);

	// faster oscillator on the two upper ranges
	wire [8:0] div_max = range_sel[1] ? 9'(DIV_FAST - 1) : 9'(DIV_SLOW - 1);
	wire osc_tick = active && (osc_div_reg >= div_max); // at or past, so a range change cannot run away

	// cycles per conversion from the width code
	wire [1:0] width_code = {op_setup.cycle_width_hi, op_setup.cycle_width_lo};
	wire [16:0] cyc_target = (width_code == 2'h0) ? 17'(CYC_SEL0) :
		(width_code == 2'h1) ? 17'(CYC_SEL1) :
		(width_code == 2'h2) ? 17'(CYC_SEL2) : 17'(CYC_SEL3);

	// period ends at the target count, or past it after a width change, or on a restart command
	wire int_end = !op_setup.timing_source_select && osc_tick &&
		(cyc_cnt_reg >= (cyc_target - 17'h00001));
	wire ext_end = op_setup.timing_source_select && restart_stb_reg;
	wire period_end = active && (int_end || ext_end || restart_stb_reg);

	// internal oscillator divider, realigned at every period start
	always_ff @(posedge clock) begin
		if (rst) begin
			osc_div_reg <= 9'h000;
		end else if (!active || period_end || osc_tick) begin
			osc_div_reg <= 9'h000;
		end else begin
			osc_div_reg <= osc_div_reg + 9'h001;
		end
	end

	// cycle counters: held at zero while the converter is not active, cleared at each period end
	always_ff @(posedge clock) begin
		if (rst) begin
			cyc_cnt_reg <= 17'h00000;
			tally_cnt_reg <= 16'h0000;
		end else if (!active || period_end) begin
			cyc_cnt_reg <= 17'h00000;
			tally_cnt_reg <= 16'h0000;
		end else if (osc_tick) begin
			cyc_cnt_reg <= cyc_cnt_reg + 17'h00001;
			tally_cnt_reg <= tally_cnt_reg + 16'h0001;
		end
	end

	// result and tally latched at the end of each period
	always_ff @(posedge clock) begin
		if (rst) begin
			count_reg <= lsp_pkg::DATA_RESET;
			tally_reg <= lsp_pkg::DATA_RESET;
			integ_end <= 1'b0;
		end else begin
			integ_end <= period_end;
			if (period_end) begin
				count_reg <= light_level;
				tally_reg <= tally_cnt_reg + {15'h0000, osc_tick};
			end
		end
	end

endmodule

// File: design/lsp_pkg.sv
// Purpose: shared constants and types of the light sensor register port
// Assumes: 100 MHz system clock, byte-wide registers behind a two-wire slave
// Notes: all offsets, field positions, reset values and timing counts live here
package lsp_pkg;

	// slave address, upper six bits fixed, low bit from the strap
	localparam logic [5:0] ADDR_UPPER = 6'h22;

	// register offsets
	localparam logic [7:0] OFF_OP_SETUP = 8'h00;
	localparam logic [7:0] OFF_RANGE_SETUP = 8'h01;
	localparam logic [7:0] OFF_COUNT_LOW = 8'h04;
	localparam logic [7:0] OFF_COUNT_HIGH = 8'h05;
	localparam logic [7:0] OFF_TALLY_LOW = 8'h06;
	localparam logic [7:0] OFF_TALLY_HIGH = 8'h07;

	// command bits carried in the register pointer byte
	localparam int PTR_RESTART_BIT = 7;
	localparam int PTR_IRQ_CLEAR_BIT = 6;

	// field positions in the range register
	localparam int RANGE_LSB = 2;
	localparam int RANGE_MSB = 3;

	// reset values
	localparam logic [7:0] OP_SETUP_RESET = 8'h00;
	localparam logic [7:0] RANGE_SETUP_RESET = 8'h00;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	// conversion mode that produces light counts
	localparam logic [1:0] MODE_LIGHT = 2'h2;

	// internal oscillator rates and derived divider lengths
	localparam int CLK_KHZ = 100000;
	localparam int OSC_SLOW_KHZ = 342;
	localparam int OSC_FAST_KHZ = 684;
	localparam int OSC_DIV_SLOW = CLK_KHZ / OSC_SLOW_KHZ;
	localparam int OSC_DIV_FAST = CLK_KHZ / OSC_FAST_KHZ;

	// oscillator cycles per conversion for each width code
	localparam int CYC_W0 = 65536;
	localparam int CYC_W1 = 4096;
	localparam int CYC_W2 = 256;
	localparam int CYC_W3 = 16;

	// layout of the operation setup register
	typedef struct packed {
		logic converter_run_bit;
		logic power_down_bit;
		logic timing_source_select;
		logic zero_bit;
		logic conv_mode_hi;
		logic conv_mode_lo;
		logic cycle_width_hi;
		logic cycle_width_lo;
	} lsp_op_setup_t;

	// synchronised pin levels
	typedef struct packed {
		logic scl;
		logic sda;
		logic strap;
	} lsp_pins_t;

endpackage

// File: design/lsp_sync2.sv
// Purpose: two-stage synchroniser for a bundle of asynchronous pin levels
// Assumes: each bit is an independent level
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module lsp_sync2 #(
	parameter int WIDTH = 3
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg; // first stage, metastability catcher

	// two flops in a row
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_reg <= '1;
			sync_out <= '1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

// File: design/lsp_top_fix.sv
// Purpose: spare design file, holds no logic
// Assumes: nothing
// Notes: no module here
`timescale 1ns/1ps

// File: bench/lsp_assertions.sv
// Purpose: port checks of the light sensor register port
// Assumes: one clock domain, synchronous active-high reset
// Notes: attached to every lsp_top by the bind below
`timescale 1ns/1ps
module lsp_assertions (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic irq_event,
	input wire lsp_pkg::lsp_op_setup_t op_setup,
	input wire logic [1:0] range_sel,
	input wire logic integ_end,
	input wire logic irq_pending
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// open drain: never drive a one
	a_sda_low_only: assert property (sda_out == 1'b0) else $error("data pin driven high");
	// reset leaves setup cleared and the pin released
	a_reset_clears: assert property (disable iff (1'b0) rst |=> op_setup == 8'h00 && range_sel == 2'h0
		&& !sda_oe && !irq_pending && !integ_end) else $error("reset values wrong");
	// bit four of the setup reads zero
	a_zero_bit: assert property (op_setup.zero_bit == 1'b0) else $error("setup bit four set");
	// setup only moves at a bus write, while the bus clock is low
	a_setup_hold: assert property (!$past(rst) && (op_setup != $past(op_setup) || range_sel != $past(range_sel))
		|-> !scl_in && !$past(scl_in)) else $error("setup changed outside a write");
	// period end is a single-cycle pulse
	a_end_pulse: assert property (integ_end |=> !integ_end) else $error("period end pulse too long");
	// no period end unless the converter runs in light mode
	a_end_active: assert property (integ_end |-> $past(op_setup.converter_run_bit && !op_setup.power_down_bit
		&& op_setup.conv_mode_hi && !op_setup.conv_mode_lo)) else $error("period end while inactive");
	// an interrupt condition always sets the pending flag
	a_irq_set: assert property (irq_event |=> irq_pending) else $error("pending flag not set");
	// pending flag only drops through a bus command
	a_irq_sticky: assert property ($fell(irq_pending) |-> !$past(irq_event) && !scl_in) else $error("flag lost");
	// the data pin only changes while the bus clock is low
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved at clock high");
	c_period: cover property (integ_end);
	c_clear: cover property ($fell(irq_pending));
	c_ack: cover property ($rose(sda_oe));
endmodule

bind lsp_top lsp_assertions lsp_assertions_i (.clock, .rst, .scl_in, .sda_out, .sda_oe, .irq_event, .op_setup,
	.range_sel, .integ_end, .irq_pending);

// File: bench/lsp_i2c_master.sv
// Purpose: bus master model driving the two-wire port
// Assumes: 160 ns bus period, pull-up on the data line
// Notes: clock line stands high between frames
`timescale 1ns/1ps
module lsp_i2c_master (
	input wire logic clock,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic sda_drv; // master level, 1 = released
	// wired-and of both parties with pull-up
	assign sda = sda_drv & ~sda_oe;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// quarter of the bus period
	task automatic quarter();
		repeat (4) @(posedge clock);
	endtask
	// data set while clock low, sampled in the high half
	task automatic bit_x(input logic b, output logic r);
		sda_drv <= b;
		quarter();
		scl <= 1'b1;
		quarter();
		r = sda;
		quarter();
		scl <= 1'b0;
		quarter();
	endtask
	// start or repeated start
	task automatic start();
		sda_drv <= 1'b1;
		quarter();
		scl <= 1'b1;
		quarter();
		sda_drv <= 1'b0;
		quarter();
		scl <= 1'b0;
		quarter();
	endtask
	// stop, data rises under high clock
	task automatic stop();
		sda_drv <= 1'b0;
		quarter();
		scl <= 1'b1;
		quarter();
		sda_drv <= 1'b1;
		quarter();
	endtask
	// eight bits msb first, then the acknowledge slot
	task automatic byte_x(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(ack_in, ack);
	endtask
endmodule

// File: bench/test_lsp_top.sv
// Purpose: self-checking bench of the light sensor register port
// Assumes: shortened cycle counts and oscillator dividers
// Notes: bench model keeps the register file and the expected periods
`timescale 1ns/1ps
module test_lsp_top;
	localparam int CYC [4] = '{64, 32, 24, 16}; // shortened cycle counts
	localparam int DIV_S = 4;
	localparam int DIV_F = 2;
	logic clock, rst, scl_in, sda_in, sda_out, sda_oe, addr_strap_pin, irq_event, integ_end, irq_pending;
	logic [15:0] light_level;
	logic [1:0] range_sel;
	lsp_pkg::lsp_op_setup_t op_setup;
	logic [7:0] q, v;
	logic ack, aack, hit;
	logic [6:0] dev;
	logic [7:0] idle_ops [5] = '{8'h80, 8'h84, 8'h8C, 8'hC8, 8'h08}; // modes 00 01 11, power-down, stopped
	int fail_count = 0;
	int compares = 0;
	int seed = 45;
	int mreg [8]; // bench model of the registers
	int ends = 0;
	int e0, cyc, last_end, last_gap;
	lsp_top #(.CYC_SEL0(CYC[0]), .CYC_SEL1(CYC[1]), .CYC_SEL2(CYC[2]), .CYC_SEL3(CYC[3]), .DIV_SLOW(DIV_S),
		.DIV_FAST(DIV_F)) lsp_top_i (.clock, .rst, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_strap_pin,
		.light_level, .irq_event, .op_setup, .range_sel, .integ_end, .irq_pending);
	lsp_i2c_master lsp_i2c_master_i (.clock, .sda_oe, .scl(scl_in), .sda(sda_in));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic bx(input logic [7:0] d, input logic a_in);
		lsp_i2c_master_i.byte_x(d, a_in, q, ack);
	endtask
	// write: address, pointer, then n copies of one data byte
	task automatic wr(input logic [6:0] da, input logic [7:0] ptr, input logic [7:0] d, input int n);
		hit = (da == {lsp_pkg::ADDR_UPPER, addr_strap_pin});
		lsp_i2c_master_i.start();
		bx({da, 1'b0}, 1'b1);
		aack = ack;
		bx(ptr, 1'b1);
		repeat (n) bx(d, 1'b1);
		lsp_i2c_master_i.stop();
		check(16'(aack), 16'(!hit));
		check(16'(ack), 16'(!hit));
		if (hit && n > 0 && ptr < 8'h02) begin
			mreg[ptr] = int'(d & (ptr == 8'h00 ? 8'hEF : 8'h0C));
		end
	endtask
	// read one register twice: master acks, then nacks
	task automatic rd(input logic [7:0] ptr, input int exp);
		lsp_i2c_master_i.start();
		bx({dev, 1'b0}, 1'b1);
		bx(ptr, 1'b1);
		lsp_i2c_master_i.start();
		bx({dev, 1'b1}, 1'b1);
		bx(8'hFF, 1'b0);
		check(16'(q), 16'(exp));
		bx(8'hFF, 1'b1);
		check(16'(q), 16'(exp));
		lsp_i2c_master_i.stop();
	endtask
	// clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// period-end counter and last gap in cycles
	always @(posedge clock) begin
		cyc++;
		if (integ_end === 1'b1) begin
			ends++;
			last_gap = cyc - last_end;
			last_end = cyc;
		end
	end
	// watchdog
	initial begin
		#1000000;
		fail_count++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		addr_strap_pin = 1'b0;
		irq_event = 1'b0;
		light_level = 16'h0000;
		dev = 7'h44;
		foreach (mreg[i]) mreg[i] = 0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (10) @(posedge clock);
		for (int a = 0; a < 8; a++) rd(8'(a), 0);
		$display("reset values done");
		repeat (4) begin
			v = 8'($random(seed));
			wr(dev, 8'h00, v, 2);
			wr(dev, 8'h01, ~v, 1);
			rd(8'h00, mreg[0]);
			rd(8'h01, mreg[1]);
			check(16'(op_setup), 16'(mreg[0]));
			check(16'(range_sel), 16'(mreg[1] >> 2));
		end
		wr(7'h45, 8'h00, 8'h55, 1);
		addr_strap_pin <= 1'b1;
		dev = 7'h45;
		repeat (8) @(posedge clock);
		wr(dev, 8'h01, 8'hF3, 1);
		rd(8'h01, mreg[1]);
		addr_strap_pin <= 1'b0;
		dev = 7'h44;
		repeat (8) @(posedge clock);
		$display("register access done");
		for (int w = 0; w < 4; w++) begin
			light_level <= 16'($random(seed));
			wr(dev, 8'h01, 8'(w << 2), 1);
			wr(dev, 8'h00, 8'h88 | 8'(w), 1);
			e0 = ends;
			repeat (3000) if (ends < e0 + 3) @(posedge clock);
			check(16'(last_gap), 16'(CYC[w] * (w < 2 ? DIV_S : DIV_F)));
			rd(8'h04, int'(light_level[7:0]));
			rd(8'h05, int'(light_level[15:8]));
			rd(8'h06, CYC[w] & 255);
			rd(8'h07, CYC[w] >> 8);
		end
		$display("conversion timing done");
		foreach (idle_ops[i]) begin
			wr(dev, 8'h00, idle_ops[i], 1);
			e0 = ends;
			repeat (600) @(posedge clock);
			check(16'(ends - e0), 16'h0000);
		end
		wr(dev, 8'h00, 8'hA8, 1);
		e0 = ends;
		wr(dev, 8'h80, 8'h00, 0);
		repeat (20) @(posedge clock);
		check(16'(ends - e0), 16'h0001);
		$display("restart command done");
		irq_event <= 1'b1;
		@(posedge clock);
		irq_event <= 1'b0;
		repeat (3) @(posedge clock);
		check(16'(irq_pending), 16'h0001);
		wr(dev, 8'h40, 8'h00, 0);
		check(16'(irq_pending), 16'h0000);
		check(16'(op_setup), 16'(mreg[0]));
		$display("interrupt clear done");
		close_out();
	end
endmodule
